// ---- verilog/rfp_pkg.sv ----
// Shared constants, register map and helpers for regulator fault protection
package rfp_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_REG   = 11;
    localparam int NUM_KIND  = 3;
    localparam int KIND_UV   = 0;
    localparam int KIND_OV   = 1;
    localparam int KIND_CURRENT_LIMIT_FAULT = 2;
    localparam int LDO2_IDX  = 8;
    localparam int AW        = 5;
    localparam int DW        = 16;
    localparam int TW        = 15;
    localparam int NUM_PINS  = NUM_KIND * NUM_REG + 2;

    // ------------------------------------------------------------
    // Timing: one prescaled tick, durations in microseconds
    // ------------------------------------------------------------
    localparam int CLK_MHZ      = 200;
    localparam int TICK_US      = 100;
    localparam int TICK_CYC     = CLK_MHZ * TICK_US;
    localparam int CURRENT_LIMIT_FAULT_DB_US   = 1000;
    localparam int PERSIST_US   = 300;
    localparam int REEN_WAIT_US = 500;
    localparam int HOLD1_US     = 1500;
    localparam int HOLD2_US     = 5000;
    localparam int HOLD3_US     = 10000;
    localparam int MS_US        = 1000;
    localparam int TMR_TOP_MS   = 2056;
    localparam logic [3:0] CURRENT_LIMIT_FAULT_DB_TK = 4'(CURRENT_LIMIT_FAULT_DB_US / TICK_US);
    localparam logic [3:0] PERSIST_TK = 4'((PERSIST_US + TICK_US - 1) / TICK_US);
    localparam logic [3:0] REEN_TK    = 4'(REEN_WAIT_US / TICK_US);
    localparam logic [3:0] TMR_MAX_CODE = 4'ha;
    localparam logic [3:0] TMR_TOP_CODE = 4'hb;

    // ------------------------------------------------------------
    // Register map (word index), fields and reset values
    // ------------------------------------------------------------
    localparam logic [AW-1:0] A_KEEP      = 5'h00;  // +kind
    localparam logic [AW-1:0] A_BYPASS    = 5'h04;  // +kind
    localparam logic [AW-1:0] A_LATCH     = 5'h08;  // +kind, write 1 clears
    localparam logic [AW-1:0] A_MASK      = 5'h0c;  // +kind
    localparam logic [AW-1:0] A_REEN      = 5'h10;
    localparam logic [AW-1:0] A_ENABLE    = 5'h11;
    localparam logic [AW-1:0] A_CTRL      = 5'h12;
    localparam logic [AW-1:0] A_COUNT     = 5'h13;
    localparam logic [AW-1:0] A_STATUS    = 5'h14;
    localparam logic [AW-1:0] A_HOST_STAT = 5'h1f;
    localparam int F_UVDB   = 0;
    localparam int F_OVDB   = 2;
    localparam int F_TMR    = 4;
    localparam int F_LIM    = 8;
    localparam int F_PINCTL = 12;
    localparam logic [NUM_REG-1:0] EN_RST = 11'h7ff;

    typedef enum logic [1:0] {
        RFP_PD_ON    = 2'b00,
        RFP_PD_SEQ   = 2'b01,
        RFP_PD_HOLD  = 2'b10,
        RFP_PD_READY = 2'b11
    } rfp_pd_e;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Over/undervoltage debounce select: 1, 2, 4 or 8 ticks
    function automatic logic [3:0] rfp_db_ticks(input logic [1:0] sel);
        return 4'h1 << sel;
    endfunction : rfp_db_ticks

    // Fault timer code to ticks; zero means the timer never expires
    function automatic logic [TW-1:0] rfp_timer_ticks(input logic [3:0] code);
        if (code <= TMR_MAX_CODE) begin
            return TW'((1 << code) * (MS_US / TICK_US));
        end else if (code == TMR_TOP_CODE) begin
            return TW'(TMR_TOP_MS * (MS_US / TICK_US));
        end
        return '0;
    endfunction : rfp_timer_ticks

    // Post power-down hold-off code to ticks
    function automatic logic [TW-1:0] rfp_hold_ticks(input logic [1:0] code);
        unique case (code)
            2'h0: return '0;
            2'h1: return TW'(HOLD1_US / TICK_US);
            2'h2: return TW'(HOLD2_US / TICK_US);
            2'h3: return TW'(HOLD3_US / TICK_US);
        endcase
    endfunction : rfp_hold_ticks

endpackage : rfp_pkg

// ---- verilog/rfp_if.sv ----
// Register and interrupt link between the fault block and its host
`timescale 1ns/1ps
`default_nettype none
interface rfp_if;
    import rfp_pkg::*;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          wr;
    logic          rd;
    logic [DW-1:0] rdata;
    logic          irq_oe;
    logic          irq_pin_n;

    // Open-drain pin with pull-up: low only while the device pulls
    assign irq_pin_n = ~irq_oe;

    modport device(input addr, wdata, wr, rd, output rdata, irq_oe);
    modport host(output addr, wdata, wr, rd, input rdata, irq_pin_n);
endinterface : rfp_if
`default_nettype wire

// ---- verilog/rfp_host.sv ----
// Host end: forwards register accesses and watches the interrupt pin
`timescale 1ns/1ps
`default_nettype none
module rfp_host
    import rfp_pkg::*;
(
    input  wire logic          sys_clk_i,
    input  wire logic          rst_i,
    rfp_if.host                link,
    input  wire logic [AW-1:0] cmd_addr_i,
    input  wire logic [DW-1:0] cmd_wdata_i,
    input  wire logic          cmd_wr_i,
    input  wire logic          cmd_rd_i,
    output logic      [DW-1:0] cmd_rdata_o,
    output logic               irq_pending_o
);
    // ------------------------------------------------------------
    // Access forwarding
    // ------------------------------------------------------------
    // Own status word is local; everything else goes to the device
    wire own_hit = (cmd_addr_i == A_HOST_STAT);
    assign link.addr  = cmd_addr_i;
    assign link.wdata = cmd_wdata_i;
    assign link.wr    = cmd_wr_i & ~own_hit;
    assign link.rd    = cmd_rd_i & ~own_hit;

    logic own_rd;
    logic irq_s1, irq_s2, irq_s3;
    logic irq_seen;

    // Device answers one cycle later, so only the source is remembered
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            own_rd <= 1'b0;
        end else begin
            own_rd <= cmd_rd_i & own_hit;
        end
    end

    // ------------------------------------------------------------
    // Interrupt pin synchroniser
    // ------------------------------------------------------------
    // Pin is asynchronous; level changes once the last two stages agree
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_s1   <= 1'b1;
            irq_s2   <= 1'b1;
            irq_s3   <= 1'b1;
            irq_seen <= 1'b0;
        end else begin
            irq_s1 <= link.irq_pin_n;
            irq_s2 <= irq_s1;
            irq_s3 <= irq_s2;
            if (irq_s2 == irq_s3) begin
                irq_seen <= ~irq_s3;
            end
        end
    end

    assign irq_pending_o = irq_seen;
    assign cmd_rdata_o   = own_rd ? {{(DW-1){1'b0}}, irq_seen} : link.rdata;
endmodule : rfp_host
`default_nettype wire

// ---- verilog/rfp_device.sv ----
// Device end: per-regulator fault protection and power-down hold-off
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Mask power-on request until sequence and hold-off end
// - Hold-off codes: none, 1.5, 5.0, 10 ms
// - Unprogrammed memory gives hold-off code zero
// - Monitor three fault kinds in active states
// - Unmasked fault latches pull interrupt pin low
// - Power-up restores fault configuration defaults
// - Keep-on bit per kind: 0 disables regulator
// - Current limit debounced 1 ms, disables at once
// - Voltage faults debounced, disable after 300 us
// - Re-enable bit restores regulator after fault clears
// - Restore 500 us after clear, plus limit debounce
// - Host writing enable off then on restores
// - Linear two pin control resumes after enable write
// - Four-bit fault counter increments unless at limit
// - Counter at limit starts power-down; host clears
// - Count limit loaded from memory at power-up
// - Zero limit never shuts down from counter
// - Fault timer runs during fault, expiry powers down
// - Timer code defaults from memory, host rewritable
// - Timer codes double from 1 ms; 2056; off
// - Ignored faults only latch and interrupt
module rfp_device
    import rfp_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    input  wire logic               sys_clk_i,
    input  wire logic               rst_i,
    rfp_if.device                   link,
    input  wire logic [NUM_REG-1:0] undervoltage_fault_i,
    input  wire logic [NUM_REG-1:0] overvoltage_fault_i,
    input  wire logic [NUM_REG-1:0] current_limit_fault_i,
    input  wire logic               monitor_en_i,
    input  wire logic               power_on_request_pin_i,
    input  wire logic               linear_reg2_hw_enable_pin_i,
    input  wire logic               pwrup_load_i,
    input  wire logic [3:0]         otp_fault_count_limit_i,
    input  wire logic [3:0]         otp_timer_fault_i,
    input  wire logic [1:0]         otp_post_powerdown_holdoff_i,
    input  wire logic               otp_programmed_i,
    input  wire logic               pd_done_i,
    output logic      [NUM_REG-1:0] reg_en_o,
    output logic                    powerdown_req_o,
    output logic                    power_up_req_o
);
    initial begin
        if (TICK_CYCLES < 2) $error("TICK_CYCLES must be at least 2");
    end

    // ------------------------------------------------------------
    // Pin synchronisers and tick prescaler
    // ------------------------------------------------------------
    logic [NUM_PINS-1:0] s1, s2, s3, pin_s;
    logic [31:0]         pre;
    wire                 tick = (pre == 32'(TICK_CYCLES - 1));

    // A pin change counts once the second and third stages agree
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1 <= '0; s2 <= '0; s3 <= '0; pin_s <= '0; pre <= '0;
        end else begin
            s1    <= {power_on_request_pin_i, linear_reg2_hw_enable_pin_i,
                      current_limit_fault_i, overvoltage_fault_i, undervoltage_fault_i};
            s2    <= s1;
            s3    <= s2;
            pin_s <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & pin_s);
            pre   <= tick ? '0 : pre + 32'h1;
        end
    end
    wire power_on_request_pin_s = pin_s[NUM_PINS-1];
    wire ldo2_pin_s = pin_s[NUM_PINS-2];

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [NUM_REG-1:0] keep [NUM_KIND];
    logic [NUM_REG-1:0] byp  [NUM_KIND];
    logic [NUM_REG-1:0] lat  [NUM_KIND];
    logic [NUM_REG-1:0] msk  [NUM_KIND];
    logic [NUM_REG-1:0] lat_set [NUM_KIND];
    logic [NUM_REG-1:0] reen, en_bits;
    logic [DW-1:0]      ctrl;
    logic [3:0]         fcnt;
    logic [1:0]         hold_code;
    rfp_pd_e            pd_state;
    logic [NUM_REG-1:0] off_v;
    logic [DW-1:0]      rd_mux;

    wire [1:0] undervoltage_debounce_sel   = ctrl[F_UVDB +: 2];
    wire [1:0] overvoltage_debounce_sel   = ctrl[F_OVDB +: 2];
    wire [3:0] tmr_cd  = ctrl[F_TMR +: 4];
    wire [3:0] limit   = ctrl[F_LIM +: 4];
    wire       pin_ctl = ctrl[F_PINCTL];
    wire [1:0] kidx    = link.addr[1:0];
    wire       kok     = (kidx != 2'h3);
    wire       wr_grp  = link.wr & kok;
    wire [AW-1:0] base = {link.addr[AW-1:2], 2'h0};
    wire       wr_cnt  = link.wr & (link.addr == A_COUNT);
    wire [NUM_REG-1:0] w11 = link.wdata[NUM_REG-1:0];
    wire [NUM_REG-1:0] en_clear = (link.wr && link.addr == A_ENABLE) ? ~w11 : '0;

    // Configuration goes back to defaults on every power-up load
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int k = 0; k < NUM_KIND; k++) begin
                keep[k] <= '0; byp[k] <= '0; msk[k] <= '0; lat[k] <= '0;
            end
            reen <= '0; en_bits <= EN_RST; ctrl <= '0; hold_code <= 2'h0;
        end else if (pwrup_load_i) begin
            for (int k = 0; k < NUM_KIND; k++) begin
                keep[k] <= '0; byp[k] <= '0; msk[k] <= '0;
                lat[k]  <= lat[k] | lat_set[k];
            end
            reen    <= '0;
            en_bits <= EN_RST;
            ctrl    <= '0;
            ctrl[F_LIM +: 4] <= otp_fault_count_limit_i;
            ctrl[F_TMR +: 4] <= otp_timer_fault_i;
            hold_code <= otp_programmed_i ? otp_post_powerdown_holdoff_i : 2'h0;
        end else begin
            for (int k = 0; k < NUM_KIND; k++) begin
                if (wr_grp && kidx == 2'(k) && base == A_KEEP) keep[k] <= w11;
                if (wr_grp && kidx == 2'(k) && base == A_BYPASS) byp[k] <= w11;
                if (wr_grp && kidx == 2'(k) && base == A_MASK) msk[k] <= w11;
                // Hardware set wins over a write-one clear
                lat[k] <= (lat[k] & ~((wr_grp && kidx == 2'(k) && base == A_LATCH) ? w11 : '0))
                          | lat_set[k];
            end
            if (link.wr && link.addr == A_REEN) reen <= w11;
            if (link.wr && link.addr == A_ENABLE) en_bits <= w11;
            if (link.wr && link.addr == A_CTRL) ctrl <= link.wdata;
        end
    end

    // ------------------------------------------------------------
    // Debounce per regulator and fault kind
    // ------------------------------------------------------------
    logic det [NUM_KIND*NUM_REG];
    logic [3:0] dcnt [NUM_KIND*NUM_REG];
    logic [NUM_REG-1:0] det_v [NUM_KIND];
    logic [NUM_REG-1:0] det_p [NUM_KIND];
    logic [NUM_REG-1:0] eff [NUM_KIND];
    for (genvar k = 0; k < NUM_KIND; k++) begin : g_kind
        for (genvar r = 0; r < NUM_REG; r++) begin : g_reg
            localparam int I = k * NUM_REG + r;
            wire raw = pin_s[I];
            wire [3:0] tgt = (k == KIND_CURRENT_LIMIT_FAULT) ? CURRENT_LIMIT_FAULT_DB_TK
                           : rfp_db_ticks(k == KIND_UV ? undervoltage_debounce_sel : overvoltage_debounce_sel);
            // Voltage faults drop at once; current limit waits on removal too
            always_ff @(posedge sys_clk_i or posedge rst_i) begin
                if (rst_i) begin
                    det[I] <= 1'b0; dcnt[I] <= 4'h0;
                end else if (!monitor_en_i) begin
                    det[I] <= 1'b0; dcnt[I] <= 4'h0;
                end else if (raw == det[I]) begin
                    dcnt[I] <= 4'h0;
                end else if (k != KIND_CURRENT_LIMIT_FAULT && !raw) begin
                    det[I] <= 1'b0;
                end else if (tick) begin
                    if (dcnt[I] + 4'h1 >= tgt) begin
                        det[I] <= raw; dcnt[I] <= 4'h0;
                    end else begin
                        dcnt[I] <= dcnt[I] + 4'h1;
                    end
                end
            end
            assign det_v[k][r] = det[I];
        end
        assign eff[k] = det_v[k] & ~byp[k];
        assign lat_set[k] = det_v[k] & ~det_p[k];
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int k = 0; k < NUM_KIND; k++) det_p[k] <= '0;
        end else begin
            for (int k = 0; k < NUM_KIND; k++) det_p[k] <= det_v[k];
        end
    end

    // ------------------------------------------------------------
    // Regulator disable and re-enable
    // ------------------------------------------------------------
    wire [NUM_REG-1:0] dis_il = eff[KIND_CURRENT_LIMIT_FAULT] & ~keep[KIND_CURRENT_LIMIT_FAULT];
    wire [NUM_REG-1:0] dis_vf = (eff[KIND_UV] & ~keep[KIND_UV]) | (eff[KIND_OV] & ~keep[KIND_OV]);
    wire [NUM_REG-1:0] any_eff = eff[KIND_UV] | eff[KIND_OV] | eff[KIND_CURRENT_LIMIT_FAULT];
    logic [3:0] ocnt [NUM_REG];
    for (genvar r = 0; r < NUM_REG; r++) begin : g_off
        // One counter times the persist wait while on, the restore wait while off
        always_ff @(posedge sys_clk_i or posedge rst_i) begin
            if (rst_i) begin
                off_v[r] <= 1'b0; ocnt[r] <= 4'h0;
            end else if (!off_v[r]) begin
                if (dis_il[r]) begin
                    off_v[r] <= 1'b1; ocnt[r] <= 4'h0;
                end else if (!dis_vf[r]) begin
                    ocnt[r] <= 4'h0;
                end else if (tick) begin
                    off_v[r] <= (ocnt[r] + 4'h1 >= PERSIST_TK);
                    ocnt[r]  <= (ocnt[r] + 4'h1 >= PERSIST_TK) ? 4'h0 : ocnt[r] + 4'h1;
                end
            end else if (en_clear[r]) begin
                off_v[r] <= 1'b0; ocnt[r] <= 4'h0;
            end else if (!reen[r] || any_eff[r]) begin
                ocnt[r] <= 4'h0;
            end else if (tick) begin
                off_v[r] <= !(ocnt[r] + 4'h1 >= REEN_TK);
                ocnt[r]  <= ocnt[r] + 4'h1;
            end
        end
    end

    // Linear regulator two follows its pin when pin control is on
    wire [NUM_REG-1:0] req_en = pin_ctl ? ((en_bits & ~(11'h1 << LDO2_IDX))
                              | (NUM_REG'(ldo2_pin_s) << LDO2_IDX)) : en_bits;

    // ------------------------------------------------------------
    // Fault counter, fault timer, power-down and hold-off
    // ------------------------------------------------------------
    logic [TW-1:0] tmr, hcnt;
    wire new_evt = |((eff[KIND_UV] & ~det_p[KIND_UV]) | (eff[KIND_OV] & ~det_p[KIND_OV])
                     | (eff[KIND_CURRENT_LIMIT_FAULT] & ~det_p[KIND_CURRENT_LIMIT_FAULT]));
    wire inc = new_evt && (fcnt != limit);
    wire cnt_trip = (limit != 4'h0) && (fcnt == limit);
    wire [TW-1:0] tmr_lim = rfp_timer_ticks(tmr_cd);
    wire tmr_trip = (tmr_lim != '0) && tick && (tmr + TW'(1) >= tmr_lim);
    wire pd_trig = cnt_trip | tmr_trip;
    wire [TW-1:0] hold_lim = rfp_hold_ticks(hold_code);

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            fcnt <= 4'h0; tmr <= '0;
        end else begin
            fcnt <= (wr_cnt || pwrup_load_i) ? {3'h0, inc} : fcnt + {3'h0, inc};
            tmr  <= (~|any_eff || tmr_lim == '0) ? '0 : (tick ? tmr + TW'(1) : tmr);
        end
    end

    // Power-on request masked from power-down start to end of hold-off
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pd_state <= RFP_PD_READY; hcnt <= '0;
            powerdown_req_o <= 1'b0; power_up_req_o <= 1'b0; reg_en_o <= '0;
            link.rdata <= '0; link.irq_oe <= 1'b0;
        end else begin
            unique case (pd_state)
                RFP_PD_ON:    if (pd_trig) pd_state <= RFP_PD_SEQ;
                RFP_PD_SEQ:   if (pd_done_i) pd_state <= RFP_PD_HOLD;
                RFP_PD_HOLD:  if (hcnt >= hold_lim) pd_state <= RFP_PD_READY;
                RFP_PD_READY: if (pwrup_load_i) pd_state <= RFP_PD_ON;
            endcase
            hcnt <= (pd_state == RFP_PD_HOLD && tick) ? hcnt + TW'(1)
                  : ((pd_state == RFP_PD_HOLD) ? hcnt : '0);
            powerdown_req_o <= (pd_state == RFP_PD_ON) && pd_trig;
            power_up_req_o  <= power_on_request_pin_s && (pd_state == RFP_PD_ON || pd_state == RFP_PD_READY);
            reg_en_o        <= (pd_state == RFP_PD_ON) ? (req_en & ~off_v) : '0;
            link.rdata      <= link.rd ? rd_mux : '0;
            link.irq_oe     <= |((lat[0] & ~msk[0]) | (lat[1] & ~msk[1])
                                 | (lat[2] & ~msk[2]));
        end
    end

    // ------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------
    always_comb begin
        rd_mux = '0;
        if (kok && base == A_KEEP)   rd_mux = DW'(keep[kidx]);
        if (kok && base == A_BYPASS) rd_mux = DW'(byp[kidx]);
        if (kok && base == A_LATCH)  rd_mux = DW'(lat[kidx]);
        if (kok && base == A_MASK)   rd_mux = DW'(msk[kidx]);
        if (link.addr == A_REEN)     rd_mux = DW'(reen);
        if (link.addr == A_ENABLE)   rd_mux = DW'(en_bits);
        if (link.addr == A_CTRL)     rd_mux = ctrl;
        if (link.addr == A_COUNT)    rd_mux = DW'(fcnt);
        if (link.addr == A_STATUS)   rd_mux = DW'({pd_state, off_v});
    end
endmodule : rfp_device
`default_nettype wire

// ---- test/rfp_asserts.sv ----
// Checker on the register and interrupt link of the fault block
`timescale 1ns/1ps
`default_nettype none
module rfp_asserts
    import rfp_pkg::*;
(
    input wire logic          sys_clk_i,
    input wire logic          rst_i,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    input wire logic          wr,
    input wire logic          rd,
    input wire logic [DW-1:0] rdata,
    input wire logic          irq_oe,
    input wire logic          irq_pin_n
);
    // ------------------------------------------------------------
    // Link properties, all in the one clock domain
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    // Read data must be zero outside its slot, else the host mux would pick up noise
    property p_idle; !$past(rd) |-> rdata == '0; endproperty
    a_idle: assert property (p_idle) else $error("read data off slot");
    property p_pin; irq_pin_n == !irq_oe; endproperty
    a_pin: assert property (p_pin) else $error("pin level wrong");
    property p_drop; $fell(irq_oe) |-> $past(wr) || $past(wr, 2); endproperty
    a_drop: assert property (p_drop) else $error("irq dropped alone");
    property p_clr; wr && addr == A_COUNT ##1 rd && addr == A_COUNT |=> rdata <= 16'h0001;
    endproperty
    a_clr: assert property (p_clr) else $error("count not cleared");
    property p_cnt; rd && addr == A_COUNT |=> rdata[15:4] == '0; endproperty
    a_cnt: assert property (p_cnt) else $error("count too wide");
    property p_keep; rd && addr <= A_ENABLE |=> rdata[15:11] == '0; endproperty
    a_keep: assert property (p_keep) else $error("regulator field too wide");
    property p_kind; rd && addr < A_REEN && addr[1:0] == 2'h3 |=> rdata == '0; endproperty
    a_kind: assert property (p_kind) else $error("fourth kind not empty");
    property p_map; rd && addr > A_STATUS |=> rdata == '0; endproperty
    a_map: assert property (p_map) else $error("unmapped read not zero");
    c_cnt: cover property (rd && addr == A_COUNT);
    c_irq: cover property ($rose(irq_oe));
    c_clr: cover property (wr && addr[4:2] == 3'h2);
endmodule : rfp_asserts
`default_nettype wire

// ---- test/tb.sv ----
// Testbench joining the host and device ends of the fault block
`timescale 1ns/1ps
`default_nettype none
module tb
    import rfp_pkg::*;
;
    // ------------------------------------------------------------
    // Stimulus, instances and tests
    // ------------------------------------------------------------
    logic               sys_clk_i = 1'b0, rst_i = 1'b1, cmd_wr = 1'b0, cmd_rd = 1'b0;
    logic               pon_pin = 1'b0, pwrup = 1'b0, pd_done = 1'b0, irq_pend, pd_req, pu_req;
    logic               mon_en = 1'b1;
    logic [AW-1:0]      cmd_addr = '0;
    logic [DW-1:0]      cmd_wdata = '0, cmd_rdata;
    logic [NUM_REG-1:0] flt_low = '0, flt_cur = '0, reg_en;
    logic [3:0]         otp_lim = 4'h2, otp_tmr = 4'hf;
    int                 fail_count = 0, checks_done = 0, pd_pulses = 0;

    // Clock and power-down pulse counter
    always #2.5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) if (pd_req === 1'b1) pd_pulses++;

    rfp_if rfp_if_inst ();
    rfp_host rfp_host_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(rfp_if_inst),
        .cmd_addr_i(cmd_addr), .cmd_wdata_i(cmd_wdata), .cmd_wr_i(cmd_wr), .cmd_rd_i(cmd_rd),
        .cmd_rdata_o(cmd_rdata), .irq_pending_o(irq_pend));
    // Short tick keeps the 1 ms limit debounce and 1.5 ms hold-off to a few dozen cycles
    rfp_device #(.TICK_CYCLES(4)) rfp_device_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .link(rfp_if_inst), .undervoltage_fault_i(flt_low), .overvoltage_fault_i('0),
        .current_limit_fault_i(flt_cur), .monitor_en_i(mon_en), .power_on_request_pin_i(pon_pin),
        .linear_reg2_hw_enable_pin_i(1'b0), .pwrup_load_i(pwrup), .otp_fault_count_limit_i(otp_lim),
        .otp_timer_fault_i(otp_tmr), .otp_post_powerdown_holdoff_i(2'h1), .otp_programmed_i(1'b1),
        .pd_done_i(pd_done), .reg_en_o(reg_en), .powerdown_req_o(pd_req), .power_up_req_o(pu_req));
    rfp_asserts rfp_asserts_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr(rfp_if_inst.addr),
        .wdata(rfp_if_inst.wdata), .wr(rfp_if_inst.wr), .rd(rfp_if_inst.rd),
        .rdata(rfp_if_inst.rdata), .irq_oe(rfp_if_inst.irq_oe), .irq_pin_n(rfp_if_inst.irq_pin_n));

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask : cyc
    task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wreg(input logic [AW-1:0] a, input logic [DW-1:0] d);
        cmd_addr <= a;
        cmd_wdata <= d;
        cmd_wr <= 1'b1;
        cyc(1);
        cmd_wr <= 1'b0;
    endtask : wreg
    // Data stands only in the cycle after the strobe, so look just past that edge
    task automatic rchk(input logic [AW-1:0] a, input logic [DW-1:0] e);
        cmd_addr <= a;
        cmd_rd <= 1'b1;
        cyc(1);
        cmd_rd <= 1'b0;
        #1 chk(cmd_rdata, e);
    endtask : rchk
    task automatic end_of_test();
        $display("Counts: %0d checks, %0d mismatches", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test

    // Main sequence: defaults, current limit with restore, counter trip and hold-off
    initial begin
        cyc(4);
        rst_i <= 1'b0;
        cyc(1);
        pwrup <= 1'b1;
        cyc(1);
        pwrup <= 1'b0;
        cyc(2);
        rchk(A_ENABLE, 16'h07ff);
        rchk(A_CTRL, 16'h02f0);
        rchk(5'h03, 16'h0000);
        rchk(5'h15, 16'h0000);
        $display("test defaults done");
        wreg(A_REEN, 16'h0001);
        flt_cur <= 11'h001;
        cyc(30);
        chk({5'h0, reg_en}, 16'h07ff);
        cyc(30);
        chk({5'h0, reg_en}, 16'h07fe);
        rchk(A_COUNT, 16'h0001);
        rchk(A_LATCH + 5'h2, 16'h0001);
        chk({15'h0, irq_pend}, 16'h0001);
        chk(pd_pulses[15:0], 16'h0000);
        flt_cur <= 11'h000;
        cyc(30);
        chk({5'h0, reg_en}, 16'h07fe);
        cyc(70);
        chk({5'h0, reg_en}, 16'h07ff);
        wreg(A_LATCH + 5'h2, 16'h0001);
        cyc(10);
        chk({15'h0, irq_pend}, 16'h0000);
        $display("test current limit done");
        flt_low <= 11'h002;
        cyc(20);
        chk(pd_pulses[15:0], 16'h0001);
        chk({5'h0, reg_en}, 16'h0000);
        flt_low <= 11'h000;
        pon_pin <= 1'b1;
        wreg(A_COUNT, 16'h0000);
        rchk(A_COUNT, 16'h0000);
        pd_done <= 1'b1;
        cyc(1);
        pd_done <= 1'b0;
        cyc(40);
        chk({15'h0, pu_req}, 16'h0000);
        cyc(40);
        chk({15'h0, pu_req}, 16'h0001);
        $display("test power down done");
        end_of_test();
    end

    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        cyc(3000);
        fail_count++;
        end_of_test();
    end
endmodule : tb
`default_nettype wire
